/* core/spc_port_ctrl.sv */
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module spc_port_ctrl
    import spc_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // write address channel
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [AXI_AW-1:0] awaddr,
    // write data channel
    input  wire logic              wvalid,
    output logic                   wready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    // write response channel
    output logic                   bvalid,
    input  wire logic              bready,
    output logic [1:0]             bresp,
    // read address channel
    input  wire logic              arvalid,
    output logic                   arready,
    input  wire logic [AXI_AW-1:0] araddr,
    // read data channel
    output logic                   rvalid,
    input  wire logic              rready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    // configuration straps
    input  wire logic              autoneg_enable_strap,
    input  wire logic              powerdown_strap,
    input  wire logic [2:0]        mode_strap,
    // interface mode and line state
    input  wire logic              mode_select,
    input  wire logic [1:0]        net_speed,
    input  wire logic              line_link_up,
    // internal data bus
    input  wire logic [DATA_W-1:0] tx_data,
    input  wire logic              tx_valid,
    input  wire logic [DATA_W-1:0] line_rx_data,
    input  wire logic              line_rx_valid,
    output logic [DATA_W-1:0]      rx_data,
    output logic                   rx_valid,
    // port control outputs
    output logic                   link_up,
    output logic                   port_reset,
    output logic                   an_restart,
    output logic                   an_enable,
    output logic                   power_down,
    output logic [1:0]             speed_sel
);
    localparam int SR_BOUND = SRST_CYCLES;

    function automatic spc_dec_t reg_dec(input logic [AXI_AW-1:0] addr);
        logic [AXI_AW-1:0] word;
        word = {addr[AXI_AW-1:2], 2'b00};
        if (word == OFS_CTRL)
            return DEC_CTRL;
        else if (word == OFS_STAT)
            return DEC_STAT;
        else
            return DEC_NONE;
    endfunction

    spc_rst_if rst_if ();

    spc_soft_reset #(
        .CYCLES (SRST_CYCLES)
    ) u_srst (
        .aclk    (aclk),
        .aresetn (aresetn),
        .rst     (rst_if)
    );

    // bus holding state
    logic              aw_hold_q;
    logic              w_hold_q;
    logic              awready_q;
    logic              wready_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              arready_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;
    logic [AXI_AW-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;

    // control fields
    logic              loop_q;
    logic              anen_q;
    logic              pd_q;
    logic              rsv10_q;
    logic [1:0]        spd_q;
    logic              rstan_q;
    logic              boot_q;

    // registered outputs
    logic              an_restart_q;
    logic              link_up_q;
    logic [1:0]        speed_sel_q;
    logic [DATA_W-1:0] rx_data_q;
    logic              rx_valid_q;

    // handshake decode
    wire logic aw_take  = awvalid && awready_q;
    wire logic w_take   = wvalid && wready_q;
    wire logic ar_take  = arvalid && arready_q;
    wire logic wr_fire  = aw_hold_q && w_hold_q && !bvalid_q;
    wire logic aw_hold_d = aw_take || (aw_hold_q && !wr_fire);
    wire logic w_hold_d  = w_take || (w_hold_q && !wr_fire);
    wire spc_dec_t wdec = reg_dec(awaddr_q);
    wire spc_dec_t rdec = reg_dec(araddr);

    // field write strobes; only byte lanes 0 and 1 carry bits
    wire logic wr_hi = wr_fire && (wdec == DEC_CTRL) && wstrb_q[1];
    wire logic wr_lo = wr_fire && (wdec == DEC_CTRL) && wstrb_q[0];
    wire logic rst_busy = rst_if.busy;
    wire logic rst_done = rst_if.done;
    wire logic en_change = wr_hi && (wdata_q[B_ANEN] != anen_q);
    wire logic set_an = en_change || (wr_hi && wdata_q[B_RSTAN]);
    wire logic pd_boot = powerdown_strap && (mode_strap == PD_MODE);

    // speed is writable only in media-side operation
    wire logic wr_spd_hi = wr_hi && mode_select;
    wire logic wr_spd_lo = wr_lo && mode_select;
    wire logic [1:0] spd_eff = mode_select ? spd_q : net_speed;

    assign rst_if.start = wr_hi && wdata_q[B_SRST] && !rst_busy;

    // read views
    wire logic [15:0] ctrl_rd = {rst_busy, loop_q, spd_eff[0], anen_q,
                                 pd_q, rsv10_q, rstan_q, 1'b1,
                                 1'b0, spd_eff[1], 6'h00};
    wire logic [3:0] stat_rd = {pd_q, mode_select, link_up_q, rst_busy};
    wire logic [31:0] rd_word = (rdec == DEC_CTRL) ? {16'h0000, ctrl_rd} :
                                (rdec == DEC_STAT) ? {28'h0000000, stat_rd} :
                                32'h00000000;
    wire logic [1:0] rd_resp = (rdec == DEC_NONE) ? RESP_SLVERR : RESP_OKAY;
    wire logic [1:0] wr_resp = (wdec == DEC_NONE) ? RESP_SLVERR : RESP_OKAY;

    // write address and data are held independently so either may come first
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
        end
        else
        begin
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            awready_q <= !aw_hold_d;
            wready_q  <= !w_hold_d;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (aw_take)
            awaddr_q <= awaddr;
        if (w_take)
        begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_resp;
        end
        else if (bready)
            bvalid_q <= 1'b0;
    end

    // one read at a time; arready stays low until the data is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= rd_resp;
        end
        else if (rvalid_q && rready)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
        else if (!rvalid_q)
            arready_q <= 1'b1;
    end

    // straps are sampled while the synchronous reset is held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            anen_q  <= autoneg_enable_strap;
            pd_q    <= pd_boot;
            loop_q  <= RST_LOOP;
            rsv10_q <= RST_RSV10;
            spd_q   <= RST_SPEED;
            rstan_q <= 1'b0;
        end
        else
        begin
            if (rst_done)
                loop_q <= RST_LOOP;
            else if (wr_hi)
                loop_q <= wdata_q[B_LOOP];
            if (wr_hi)
            begin
                anen_q  <= wdata_q[B_ANEN];
                pd_q    <= wdata_q[B_PD];
                rsv10_q <= wdata_q[B_RSV10];
            end
            if (wr_spd_hi)
                spd_q[0] <= wdata_q[B_SPD_L];
            if (wr_spd_lo)
                spd_q[1] <= wdata_q[B_SPD_M];
            // lasts one cycle; a new set in that cycle keeps it high
            rstan_q <= set_an;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            boot_q       <= 1'b1;
            an_restart_q <= 1'b0;
            link_up_q    <= 1'b0;
        end
        else
        begin
            boot_q       <= 1'b0;
            an_restart_q <= rstan_q || boot_q || rst_done;
            // negotiation in restart means no link, so link follows it down
            link_up_q    <= line_link_up && !loop_q && !pd_q && !rst_busy
                            && !rstan_q && !an_restart_q;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            speed_sel_q <= RST_SPEED;
            rx_data_q   <= '0;
            rx_valid_q  <= 1'b0;
        end
        else
        begin
            speed_sel_q <= spd_eff;
            rx_data_q   <= loop_q ? tx_data : line_rx_data;
            rx_valid_q  <= loop_q ? tx_valid : line_rx_valid;
        end
    end

    assign awready    = awready_q;
    assign wready     = wready_q;
    assign bvalid     = bvalid_q;
    assign bresp      = bresp_q;
    assign arready    = arready_q;
    assign rvalid     = rvalid_q;
    assign rdata      = rdata_q;
    assign rresp      = rresp_q;
    assign rx_data    = rx_data_q;
    assign rx_valid   = rx_valid_q;
    assign link_up    = link_up_q;
    assign port_reset = rst_busy;
    assign an_restart = an_restart_q;
    assign an_enable  = anen_q;
    assign power_down = pd_q;
    assign speed_sel  = speed_sel_q;

    // checks
    srst_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_hi && wdata_q[B_SRST] && !port_reset |=> port_reset)
        else $error("soft reset did not start");

    srst_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(port_reset) |-> ##[1:SR_BOUND] (!port_reset && !ctrl_rd[B_SRST]))
        else $error("soft reset bit did not clear");

    srst_after_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(port_reset) |=> an_restart && !loop_q)
        else $error("no restart after soft reset");

    loop_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
        loop_q |=> rx_data == $past(tx_data) && rx_valid == $past(tx_valid))
        else $error("loopback data mismatch");

    loop_link_a: assert property (@(posedge aclk) disable iff (!aresetn)
        loop_q |=> !link_up)
        else $error("link up during loopback");

    speed_ro_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !mode_select && ar_take && rdec == DEC_CTRL
        |=> {rdata[B_SPD_M], rdata[B_SPD_L]} == $past(net_speed) ##1
        speed_sel == $past(net_speed, 2))
        else $error("read-only speed wrong");

    speed_rw_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_hi && wr_lo && mode_select ##1 mode_select
        |=> speed_sel == $past({wdata_q[B_SPD_M], wdata_q[B_SPD_L]}, 2))
        else $error("written speed not applied");

    an_change_a: assert property (@(posedge aclk) disable iff (!aresetn)
        en_change |=> rstan_q ##1 (an_restart && !link_up) ##1 !link_up)
        else $error("enable change did not restart");

    restart_sc_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_hi && wdata_q[B_RSTAN] |=> rstan_q ##1 (an_restart && !rstan_q))
        else $error("restart bit not self clearing");

    boot_strap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> an_enable == $past(autoneg_enable_strap)
        && power_down == ($past(powerdown_strap) && $past(mode_strap) == PD_MODE)
        ##1 an_restart)
        else $error("strap load or boot restart wrong");

    rsv_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take && rdec == DEC_CTRL
        |=> rdata[8] && !rdata[7] && rdata[5:0] == 6'h00 && rdata[31:16] == 16'h0000)
        else $error("reserved bits wrong");
endmodule

/* shared/spc_pkg.sv */
// Summary of operation
// - writing 1 to bit 15 resets the port state machines of this bank
// - soft reset starts at once; bit 15 clears itself when reset completes
// - loopback bit 14 returns internal transmit data onto the receive path
// - while loopback is on, the port link is forced down
// - mode-select 0: speed bits 6 and 13 are read-only, showing resolved speed
// - mode-select 1: speed bits writable; 10 means 1000 Mbps, 01 means 100 Mbps
// - any change of auto-negotiation enable bit 12 breaks link, restarts negotiation
// - hardware reset loads bit 12 from its strap; soft reset keeps it
// - hardware reset sets power-down bit 11 only if strap 1 and mode strap 101
// - writing 1 to bit 9 restarts negotiation, then the bit clears itself
// - negotiation restarts after hardware reset, soft reset or enable change
// - toggling enable bit 12 sets restart bit 9 to 1
// - mode-select 0 means system-side, 1 means media-side serial operation
package spc_pkg;

    // bus geometry
    localparam int AXI_AW = 8;

    // register byte offsets
    localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_STAT = 8'h04;

    // control register field positions
    localparam int B_SRST  = 15;
    localparam int B_LOOP  = 14;
    localparam int B_SPD_L = 13;
    localparam int B_ANEN  = 12;
    localparam int B_PD    = 11;
    localparam int B_RSV10 = 10;
    localparam int B_RSTAN = 9;
    localparam int B_SPD_M = 6;

    // values after hardware reset
    localparam logic [1:0] RST_SPEED = 2'h2;
    localparam logic       RST_LOOP  = 1'h0;
    localparam logic       RST_RSV10 = 1'h0;

    // mode strap value that lets the power-down strap act
    localparam logic [2:0] PD_MODE = 3'h5;

    // length of the port soft reset in clock cycles
    localparam int SRST_CYCLES = 16;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // register decode results
    typedef enum logic [1:0] {
        DEC_NONE = 2'b00,
        DEC_CTRL = 2'b01,
        DEC_STAT = 2'b10
    } spc_dec_t;

    // soft reset sequencer states
    typedef enum logic {
        SR_IDLE = 1'b0,
        SR_BUSY = 1'b1
    } spc_sr_state_t;

endpackage

/* shared/spc_rst_if.sv */
`timescale 1ns/1ps
interface spc_rst_if;
    logic start;
    logic busy;
    logic done;

    modport ctrl
    (
        output start,
        input  busy,
        input  done
    );

    modport seq
    (
        input  start,
        output busy,
        output done
    );
endinterface

/* core/spc_soft_reset.sv */
`timescale 1ns/1ps
module spc_soft_reset
    import spc_pkg::*;
#(
    parameter int CYCLES = SRST_CYCLES
)
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // request and progress
    spc_rst_if.seq    rst
);
    localparam int CW = $clog2(CYCLES + 1);

    spc_sr_state_t   state_q;
    spc_sr_state_t   state_d;
    logic [CW-1:0]   cnt_q;
    logic            done_q;
    wire logic       last = (cnt_q == CW'(CYCLES - 1));

    // a start while busy is dropped; the running reset already covers it
    always_comb
    begin
        case (state_q)
            SR_IDLE: state_d = rst.start ? SR_BUSY : SR_IDLE;
            SR_BUSY: state_d = last ? SR_IDLE : SR_BUSY;
            default: state_d = SR_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= SR_IDLE;
            cnt_q   <= '0;
            done_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= (state_q == SR_BUSY && !last) ? cnt_q + 1'b1 : '0;
            done_q  <= (state_q == SR_BUSY) && last;
        end
    end

    assign rst.busy = (state_q == SR_BUSY);
    assign rst.done = done_q;
endmodule

/* testbench/spc_line_model.sv */
`timescale 1ns/1ps
module spc_line_model
#(
    parameter logic [1:0] NET_SPEED = 2'h1,
    parameter int         DATA_W    = 8
)
(
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // line side of the port
    output logic              line_link_up,
    output logic [DATA_W-1:0] line_rx_data,
    output logic              line_rx_valid,
    output logic [1:0]        net_speed
);
    // data moves every cycle so a stuck receive path cannot hide
    always_ff @(posedge aclk)
    begin
        line_link_up  <= aresetn;
        line_rx_valid <= aresetn;
        line_rx_data  <= aresetn ? line_rx_data + DATA_W'(8'h5B) : DATA_W'(8'hA5);
    end
    assign net_speed = NET_SPEED;
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import spc_pkg::*;
    localparam logic [1:0] NSPD = 2'h2;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr, tx_data, line_rx_data, rx_data, prev_tx;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [2:0]  mode_strap;
    logic [1:0]  bresp, rresp, net_speed, speed_sel, resp, m_spd;
    logic        awready, wready, bvalid, arready, rvalid, rx_valid, link_up;
    logic        port_reset, an_restart, an_enable, power_down, line_link_up;
    logic        line_rx_valid, autoneg_enable_strap, powerdown_strap;
    logic        mode_select, tx_valid;
    int          fails = 0, cmp_count = 0, seed = 11784, an_cnt = 0;
    int          pr_cnt = 0, pr_len = 0, k0, m_loop, m_anen, m_pd, m_rsv;

    spc_port_ctrl spc_port_ctrl_i (.aclk, .aresetn, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .autoneg_enable_strap,
        .powerdown_strap, .mode_strap, .mode_select, .net_speed, .line_link_up,
        .tx_data, .tx_valid, .line_rx_data, .line_rx_valid, .rx_data, .rx_valid,
        .link_up, .port_reset, .an_restart, .an_enable, .power_down, .speed_sel);
    spc_line_model #(.NET_SPEED(NSPD)) spc_line_model_i (.aclk, .aresetn,
        .line_link_up, .line_rx_data, .line_rx_valid, .net_speed);

    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // pulse and reset-length monitors
    always @(posedge aclk)
    begin
        if (an_restart === 1'b1) an_cnt++;
        if (port_reset === 1'b1) pr_cnt++;
        else if (pr_cnt != 0)
        begin
            pr_len = pr_cnt;
            pr_cnt = 0;
        end
    end

    task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic hang(input string n);
        fails++;
        $display("mismatch %s expected answer seen none", n);
        close_out();
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 40);
        if (bvalid !== 1'b1) hang("bvalid");
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 40);
        if (rvalid !== 1'b1) hang("rvalid");
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // reference view of the control word
    function automatic logic [15:0] cur(input logic [1:0] sp);
        cur = 16'h0100 | (16'(m_loop) << 14) | (16'(m_anen) << 12) | (16'(m_pd) << 11)
            | (16'(m_rsv) << 10) | (16'(sp[0]) << 13) | (16'(sp[1]) << 6);
    endfunction

    task automatic wr_ctrl(input logic [15:0] v);
        axw(OFS_CTRL, {16'($random(seed)), v}, 4'h3);
        chk32("bresp", RESP_OKAY, resp);
        m_loop = v[14];
        m_anen = v[12];
        m_pd   = v[11];
        m_rsv  = v[10];
        if (mode_select) m_spd = {v[6], v[13]};
    endtask

    task automatic rd_ctrl(input string n);
        axr(OFS_CTRL);
        chk32(n, {16'h0, cur(mode_select ? m_spd : NSPD)}, rd);
    endtask

    task automatic do_reset(input logic an, input logic pd, input logic [2:0] md);
        @(posedge aclk);
        aresetn <= 1'b0;
        autoneg_enable_strap <= an;
        powerdown_strap <= pd;
        mode_strap <= md;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        an_cnt = 0;
        repeat (6) @(posedge aclk);
        m_loop = 0;
        m_anen = an;
        m_pd = pd && md == PD_MODE;
        m_rsv = 0;
        m_spd = 2'h2;
    endtask

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, tx_valid} = '0;
        {awaddr, araddr, tx_data, wdata, wstrb, mode_strap} = '0;
        {autoneg_enable_strap, powerdown_strap} = '0;
        mode_select = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            do_reset(i != 1, i < 2, i == 1 ? 3'h4 : 3'h5);
            rd_ctrl("ctrl after reset");
            chk32("an_enable", m_anen, an_enable);
            chk32("power_down", m_pd, power_down);
            chk32("hw restarts", 1, an_cnt);
            $display("test strap case %0d done", i);
        end
        wr_ctrl(cur(m_spd) | 16'h4000);
        tx_valid <= 1'b1;
        for (int k = 0; k < 10; k++)
        begin
            @(posedge aclk);
            if (k > 1) chk32("rx path", {1'b1, prev_tx}, {rx_valid, rx_data});
            if (k > 1) chk32("link_up", 0, link_up);
            prev_tx = tx_data;
            tx_data <= 8'($random(seed));
        end
        wr_ctrl(cur(m_spd) & 16'hBFFF);
        repeat (3) @(posedge aclk);
        chk32("link_up", 1, link_up);
        prev_tx = line_rx_data;
        @(posedge aclk);
        chk32("rx line path", {1'b1, prev_tx}, {rx_valid, rx_data});
        $display("test loopback done");
        wr_ctrl((cur(2'h1) & 16'hFEFF) | 16'h00BF);
        rd_ctrl("speed written");
        chk32("speed_sel", 2'h1, speed_sel);
        mode_select <= 1'b0;
        wr_ctrl(cur(2'h2));
        rd_ctrl("speed follows line");
        chk32("speed_sel", NSPD, speed_sel);
        mode_select <= 1'b1;
        rd_ctrl("speed kept");
        $display("test speed done");
        k0 = an_cnt;
        wr_ctrl(cur(m_spd) | 16'h0200);
        repeat (4) @(posedge aclk);
        chk32("restart pulses", k0 + 1, an_cnt);
        rd_ctrl("restart cleared");
        wr_ctrl(cur(m_spd) ^ 16'h1000);
        repeat (4) @(posedge aclk);
        chk32("enable change", k0 + 2, an_cnt);
        chk32("an_enable", m_anen, an_enable);
        $display("test restart done");
        wr_ctrl(cur(m_spd) | 16'h4000);
        k0 = an_cnt;
        pr_len = 0;
        axw(OFS_CTRL, {16'h0, cur(m_spd) | 16'h8000}, 4'h3);
        axr(OFS_CTRL);
        chk32("reset busy", 32'h1, {31'h0, rd[15]});
        for (int w = 0; w < 60 && pr_len == 0; w++) @(posedge aclk);
        if (pr_len == 0) hang("port_reset");
        chk32("reset length", SRST_CYCLES, pr_len);
        repeat (3) @(posedge aclk);
        chk32("restart after reset", k0 + 1, an_cnt);
        m_loop = 0;
        rd_ctrl("after soft reset");
        $display("test soft reset done");
        axw(OFS_CTRL, 32'hFFFF_FFFF, 4'hC);
        rd_ctrl("upper lanes ignored");
        axw(8'h08, 32'h0000_FFFF, 4'h3);
        chk32("bresp unmapped", RESP_SLVERR, resp);
        axw(OFS_STAT, 32'h0000_FFFF, 4'h3);
        chk32("bresp status", RESP_OKAY, resp);
        rd_ctrl("writes elsewhere ignored");
        axr(8'h08);
        chk32("rresp unmapped", RESP_SLVERR, resp);
        chk32("rdata unmapped", 32'h0, rd);
        axr(OFS_STAT);
        chk32("status", 32'h6, rd);
        $display("test bus corners done");
        close_out();
    end
endmodule
